// [design/nve_erase_regs.sv]
// Erase command registers with AHB-Lite slave and busy sequencing toward the flash array.
// Assumes the array accepts a one-cycle start pulse; busy time is counted here.
`timescale 1ns/1ps

// Function
// R1 - Writing 1 to whole-array trigger starts full erase including config area; 0 ignored.
// R2 - Software enables erase mode first; whole erase only runs when erase enabled.
// R3 - Writing 1 to config-area trigger starts config-area erase; 0 ignored.
// R4 - Software enables erase mode first; config-area erase needs erase enabled.
// R5 - Legacy page-erase write behaves exactly like ordinary page erase.
// R6 - Partial-erase register write takes page start address and starts partial erase.
// R7 - Software enables erase before and disables after each partial erase.
// R8 - All four erase command registers reset to zero.
// R9 - Access mode encodes 0 read-only, 1 write-enabled, 2 erase-enabled.
// R10 - Ready flag reads 0 while erasing, 1 when idle.
// R11 - New erase accepted only when idle; busy held until erase finishes.
module nve_erase_regs (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic             hready,
    input  wire logic [31:0]      hwdata,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    output nve_pkg::nve_cmd_s     eraseCmd,
    output logic                  busy
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux decode
    function automatic logic [31:0] readReg(input nve_pkg::nve_state_s s, input logic [11:0] a);
        logic [31:0] v;
        v = nve_pkg::RST_ZERO;
        if (a == nve_pkg::OFF_READY) begin
            v[0] = (s.state == nve_pkg::ST_IDLE); // [R10]
        end else if (a == nve_pkg::OFF_ACCESS_MODE) begin
            v[1:0] = s.mode;
        end else if (a == nve_pkg::OFF_PAGE_WIPE) begin
            v = s.pageWipe;
        end else if (a == nve_pkg::OFF_WHOLE_ERASE) begin
            v = s.wholeErase;
        end else if (a == nve_pkg::OFF_LEGACY_PAGE) begin
            v = s.legacyPage;
        end else if (a == nve_pkg::OFF_CFG_ERASE) begin
            v = s.cfgErase;
        end else if (a == nve_pkg::OFF_PART_ADDR) begin
            v = s.partAddr;
        end else if (a == nve_pkg::OFF_PART_SETUP) begin
            v = s.partSetup;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State
    nve_pkg::nve_state_s cur;
    nve_pkg::nve_state_s next_cur;
    logic                addrPhase;
    logic                eraseOn;
    logic                idle;
    logic [31:0]         wd;

    assign addrPhase = hsel && hready && (htrans == nve_pkg::HTRANS_NONSEQ);
    assign eraseOn   = (cur.mode == nve_pkg::MODE_ERASE_EN); // [R9]
    assign idle      = (cur.state == nve_pkg::ST_IDLE);
    assign wd        = hwdata;

    always_comb begin
        next_cur           = cur;
        next_cur.cmd.start = 1'b0;
        next_cur.dphWrite  = 1'b0;
        next_cur.dphRead   = 1'b0;

        // Busy countdown; flag stays busy until the count runs out
        case (cur.state)
            nve_pkg::ST_IDLE: begin
                next_cur.count = 16'h0000;
            end
            nve_pkg::ST_BUSY: begin
                if (cur.count <= 16'h0001) begin
                    next_cur.state = nve_pkg::ST_IDLE; // [R11]
                    next_cur.count = 16'h0000;
                end else begin
                    next_cur.count = cur.count - 16'h0001;
                end
            end
            default: begin
                next_cur.state = nve_pkg::ST_IDLE;
            end
        endcase

        // Data phase of a write: store and maybe launch a command
        if (cur.dphWrite) begin
            if (cur.dphAddr == nve_pkg::OFF_ACCESS_MODE) begin
                next_cur.mode = wd[1:0]; // [R9]
            end else if (cur.dphAddr == nve_pkg::OFF_PAGE_WIPE) begin
                next_cur.pageWipe = wd;
                if (eraseOn && idle) begin
                    next_cur.cmd   = '{start: 1'b1, op: nve_pkg::OP_PAGE, addr: wd};
                    next_cur.state = nve_pkg::ST_BUSY;
                    next_cur.count = nve_pkg::PAGE_CYCLES;
                end
            end else if (cur.dphAddr == nve_pkg::OFF_WHOLE_ERASE) begin
                next_cur.wholeErase = wd;
                if (wd[0] && eraseOn && idle) begin // [R1] [R2] [R11]
                    next_cur.cmd   = '{start: 1'b1, op: nve_pkg::OP_WHOLE, addr: nve_pkg::RST_ZERO};
                    next_cur.state = nve_pkg::ST_BUSY;
                    next_cur.count = nve_pkg::WHOLE_CYCLES;
                end
            end else if (cur.dphAddr == nve_pkg::OFF_LEGACY_PAGE) begin
                next_cur.legacyPage = wd;
                if (eraseOn && idle) begin // [R5]
                    next_cur.cmd   = '{start: 1'b1, op: nve_pkg::OP_PAGE, addr: wd};
                    next_cur.state = nve_pkg::ST_BUSY;
                    next_cur.count = nve_pkg::PAGE_CYCLES;
                end
            end else if (cur.dphAddr == nve_pkg::OFF_CFG_ERASE) begin
                next_cur.cfgErase = wd;
                if (wd[0] && eraseOn && idle) begin // [R3] [R4]
                    next_cur.cmd   = '{start: 1'b1, op: nve_pkg::OP_CFG, addr: nve_pkg::RST_ZERO};
                    next_cur.state = nve_pkg::ST_BUSY;
                    next_cur.count = nve_pkg::PAGE_CYCLES;
                end
            end else if (cur.dphAddr == nve_pkg::OFF_PART_ADDR) begin
                next_cur.partAddr = wd;
                if (eraseOn && idle) begin // [R6] [R7]
                    next_cur.cmd   = '{start: 1'b1, op: nve_pkg::OP_PARTIAL, addr: wd};
                    next_cur.state = nve_pkg::ST_BUSY;
                    next_cur.count = (cur.partSetup[15:0] == 16'h0000) ? 16'h0001 : cur.partSetup[15:0];
                end
            end else if (cur.dphAddr == nve_pkg::OFF_PART_SETUP) begin
                next_cur.partSetup = wd;
            end
        end

        // Address phase capture; read data prepared for the next cycle
        if (addrPhase) begin
            next_cur.dphAddr  = haddr[11:0];
            next_cur.dphWrite = hwrite;
            next_cur.dphRead  = !hwrite;
            next_cur.rdata    = readReg(cur, haddr[11:0]);
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            cur           <= '0; // [R8]
            cur.state     <= nve_pkg::ST_IDLE;
            cur.mode      <= nve_pkg::MODE_READ_ONLY;
            cur.partSetup <= nve_pkg::RST_PART_SETUP;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops; hreadyout and hresp tied to constants
    assign hrdata    = cur.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign eraseCmd  = cur.cmd;
    assign busy      = (cur.state == nve_pkg::ST_BUSY); // [R10]

endmodule

// [design/nve_pkg.sv]
// Package for the erase command register block: offsets, fields, reset values, types.
// Assumes a single 25 MHz clock domain and an AHB-Lite register bus with 32-bit data.
package nve_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] OFF_READY       = 12'h0400;
    localparam logic [11:0] OFF_ACCESS_MODE = 12'h0504;
    localparam logic [11:0] OFF_PAGE_WIPE   = 12'h0508;
    localparam logic [11:0] OFF_WHOLE_ERASE = 12'h050c;
    localparam logic [11:0] OFF_LEGACY_PAGE = 12'h0510;
    localparam logic [11:0] OFF_CFG_ERASE   = 12'h0514;
    localparam logic [11:0] OFF_PART_ADDR   = 12'h0518;
    localparam logic [11:0] OFF_PART_SETUP  = 12'h051c;

    ////////////////////////////////////////////////////////////////////////////////
    // Field values and reset values
    localparam logic [1:0]  MODE_READ_ONLY  = 2'h0;
    localparam logic [1:0]  MODE_WRITE_EN   = 2'h1;
    localparam logic [1:0]  MODE_ERASE_EN   = 2'h2;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    localparam logic [31:0] RST_PART_SETUP  = 32'h0000_000a;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Erase durations in microseconds and clock cycles; the cycle counts are loaded into the busy counter
    localparam int          CLK_MHZ         = 25;
    localparam int          PAGE_ERASE_US   = 40;
    localparam int          WHOLE_ERASE_US  = 100;
    localparam logic [15:0] PAGE_CYCLES     = 16'(PAGE_ERASE_US * CLK_MHZ);
    localparam logic [15:0] WHOLE_CYCLES    = 16'(WHOLE_ERASE_US * CLK_MHZ);

    typedef enum logic [2:0] {
        OP_NONE,
        OP_WHOLE,
        OP_CFG,
        OP_PAGE,
        OP_PARTIAL
    } nve_op_e;

    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } nve_state_e;

    // Command to the flash array
    typedef struct packed {
        logic        start;
        nve_op_e     op;
        logic [31:0] addr;
    } nve_cmd_s;

    // All state of the top module except the reset synchronizer
    typedef struct packed {
        nve_state_e  state;
        logic [15:0] count;
        logic [1:0]  mode;
        logic [31:0] pageWipe;
        logic [31:0] wholeErase;
        logic [31:0] legacyPage;
        logic [31:0] cfgErase;
        logic [31:0] partAddr;
        logic [31:0] partSetup;
        logic        dphWrite;
        logic        dphRead;
        logic [11:0] dphAddr;
        logic [31:0] rdata;
        nve_cmd_s    cmd;
    } nve_state_s;

endpackage

// [verif/nve_erase_regs_props.sv]
// Checker on the erase block ports, bound below.
// Assumes a zero-wait slave; the mode field is tracked from bus writes.
`timescale 1ns/1ps
module nve_erase_regs_props (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    input  wire nve_pkg::nve_cmd_s eraseCmd,
    input  wire logic              busy
);
    logic        dWr;
    logic [11:0] dA;
    logic [1:0]  mode;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dWr  <= 1'b0;
            dA   <= 12'h000;
            mode <= 2'h0;
        end else begin
            dWr <= hsel && hready && htrans == nve_pkg::HTRANS_NONSEQ && hwrite;
            dA  <= haddr[11:0];
            if (dWr && dA == nve_pkg::OFF_ACCESS_MODE) mode <= hwdata[1:0];
        end
    end
    wire ok   = mode == nve_pkg::MODE_ERASE_EN && !busy;
    wire wAll = dWr && dA == nve_pkg::OFF_WHOLE_ERASE;
    wire wCfg = dWr && dA == nve_pkg::OFF_CFG_ERASE;
    wire wPg  = dWr && dA == nve_pkg::OFF_LEGACY_PAGE;
    wire wPt  = dWr && dA == nve_pkg::OFF_PART_ADDR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_whole_start: assert property (wAll && hwdata[0] && ok
        |=> eraseCmd.start && eraseCmd.op == nve_pkg::OP_WHOLE) else $error("whole erase not started");
    chk_cfg_start: assert property (wCfg && hwdata[0] && ok
        |=> eraseCmd.start && eraseCmd.op == nve_pkg::OP_CFG) else $error("config erase not started");
    chk_zero_noop: assert property ((wAll || wCfg) && !hwdata[0]
        |=> !eraseCmd.start) else $error("zero write started an erase");
    chk_mode_gate: assert property ((wAll || wCfg || wPg || wPt) && mode != nve_pkg::MODE_ERASE_EN
        |=> !eraseCmd.start) else $error("erase started without erase mode");
    chk_legacy_page: assert property (wPg && ok |=> eraseCmd.start
        && eraseCmd.op == nve_pkg::OP_PAGE && eraseCmd.addr == $past(hwdata)) else $error("page erase wrong");
    chk_partial_addr: assert property (wPt && ok |=> eraseCmd.start
        && eraseCmd.op == nve_pkg::OP_PARTIAL && eraseCmd.addr == $past(hwdata)) else $error("partial erase wrong");
    chk_start_pulse: assert property (eraseCmd.start
        |-> busy ##1 (busy && !eraseCmd.start) [*7]) else $error("start not a pulse or busy dropped");
    chk_idle_only: assert property (eraseCmd.start |-> !$past(busy))
        else $error("erase started while busy");
endmodule
bind nve_erase_regs nve_erase_regs_props i_props (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .eraseCmd(eraseCmd), .busy(busy)
);

// [verif/nve_erase_regs_tb.sv]
// Testbench for the erase command block: AHB-Lite master and flash stand-in.
// Assumes zero-wait answers and registered read data.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module nve_erase_regs_tb;
    logic              clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, busy;
    logic [31:0]       haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [1:0]        htrans = 2'h0;
    logic [31:0]       seed = 32'h0000_cf03;
    nve_pkg::nve_cmd_s cmd;
    int                n_errors = 0, n_tests = 0;
    logic [11:0]       regs[5] = '{nve_pkg::OFF_WHOLE_ERASE, nve_pkg::OFF_LEGACY_PAGE,
                                   nve_pkg::OFF_CFG_ERASE, nve_pkg::OFF_PART_ADDR, 12'h600};
    nve_erase_regs i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .eraseCmd(cmd), .busy(busy));
    nve_flash_model flash (.clk(clk), .cmd(cmd));
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic nve_pkg::nve_op_e expOp(input logic [11:0] a);
        case (a)
            nve_pkg::OFF_WHOLE_ERASE: return nve_pkg::OP_WHOLE;
            nve_pkg::OFF_CFG_ERASE:   return nve_pkg::OP_CFG;
            nve_pkg::OFF_PART_ADDR:   return nve_pkg::OP_PARTIAL;
            default:                  return nve_pkg::OP_PAGE;
        endcase
    endfunction
    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic waitRdy();
        int k;
        k = 0;
        do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 20);
        if (k >= 20) begin n_errors++; complete_run(); end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        hwrite <= wr;
        htrans <= nve_pkg::HTRANS_NONSEQ;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
    endtask
    task automatic erase(input logic [11:0] a, input logic [31:0] d);
        int c, n;
        xfer(1, nve_pkg::OFF_ACCESS_MODE, 32'h0000_0002);
        c = flash.nStarts;
        xfer(1, a, d);
        xfer(0, nve_pkg::OFF_READY, 0);
        `CHK("ready busy", 1'b0, rd[0])
        `CHK("op", expOp(a), flash.lastOp)
        if (a == nve_pkg::OFF_LEGACY_PAGE || a == nve_pkg::OFF_PART_ADDR || a == nve_pkg::OFF_PAGE_WIPE)
            `CHK("addr", d, flash.lastAddr)
        `CHK("hresp", 1'b0, hresp)
        xfer(1, a, d);
        `CHK("starts", c + 1, flash.nStarts)
        n = 0;
        do begin xfer(0, nve_pkg::OFF_READY, 0); n++; end while (rd[0] !== 1'b1 && n < 2000);
        `CHK("ready idle", 1'b1, rd[0])
        if (n >= 2000) complete_run();
        xfer(1, nve_pkg::OFF_ACCESS_MODE, 32'h0000_0000);
        xfer(1, a, d);
        xfer(0, a, 0);
        `CHK("stored", d, rd)
        `CHK("gated", c + 1, flash.nStarts)
    endtask
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (regs[i]) begin
            xfer(0, regs[i], 0);
            `CHK("reset value", 32'h0000_0000, rd)
        end
        xfer(0, nve_pkg::OFF_READY, 0);
        `CHK("ready reset", 1'b1, rd[0])
        xfer(1, nve_pkg::OFF_ACCESS_MODE, 32'h0000_0002);
        xfer(1, nve_pkg::OFF_WHOLE_ERASE, 0);
        xfer(1, nve_pkg::OFF_CFG_ERASE, 0);
        `CHK("zero noop", 0, flash.nStarts)
        erase(nve_pkg::OFF_WHOLE_ERASE, 32'h0000_0001);
        erase(nve_pkg::OFF_CFG_ERASE, 32'h0000_0001);
        repeat (3) begin
            erase(nve_pkg::OFF_LEGACY_PAGE, xs());
            erase(nve_pkg::OFF_PAGE_WIPE, xs());
            erase(nve_pkg::OFF_PART_ADDR, xs());
        end
        complete_run();
    end
endmodule

// [verif/nve_flash_model.sv]
// Flash array stand-in: counts erase starts, keeps the last command.
// Assumes the block sends a one-cycle start pulse with op and addr.
`timescale 1ns/1ps
module nve_flash_model (
    input  wire logic              clk,
    input  wire nve_pkg::nve_cmd_s cmd
);
    int               nStarts  = 0;
    nve_pkg::nve_op_e lastOp   = nve_pkg::OP_NONE;
    logic [31:0]      lastAddr = 32'h0000_0000;
    always @(posedge clk) begin
        if (cmd.start) begin
            nStarts  <= nStarts + 1;
            lastOp   <= cmd.op;
            lastAddr <= cmd.addr;
        end
    end
endmodule
